/* core/bemf_sense_timing_regs.v */
// Notes on behaviour
// - after the coil discharge time, wait the settle time, field 7-4 of bemf_settle_discharge_times, reset 1
// - settle codes 0-3: LRA 15/25/50/75 us, ERM 45/75/150/225 us
// - settle codes 4-15 are LRA only, 90 up to 285 us
// - wait the coil discharge time, field 3-0 of bemf_settle_discharge_times, reset 1
// - discharge codes 0-3: LRA 15/25/50/75 us, ERM 45/75/150/225 us
// - discharge codes 4-15 are LRA only, 90 up to 285 us, same steps
// - drive time codes 28-31 give 3.3-3.6 ms LRA, double for ERM
// - overdrive limit 0 = no clamp, 1-3 = 25/50/100 ms; ignored in calibration
// - sample wait around zero crossing, field 3-2 of overdrive_sample_zc_times: 150-300 us
// - crossing detect window, field 1-0 of overdrive_sample_zc_times: 100 or 200 us
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "bemf_timing_regs.vh"
module bemf_sense_timing_regs #(
   parameter [15:0] TICK_CYCLES = `TICK_CYCLES,
   parameter ADDR_W = 8
)(
   input wire mclk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_r,
   output reg pready_r,
   output reg pslverr_r,
   input wire erm_mode,
   input wire calib_or_diag,
   input wire bemf_start,
   output reg bemf_sample_go_r,
   input wire zc_seen,
   output wire amp_sample_go,
   input wire zc_window_start,
   output wire zc_window_open,
   input wire od_start,
   input wire od_stop,
   output wire od_clamp,
   input wire drive_start,
   input wire [4:0] drive_time_code,
   output wire drive_done
);
   // ----------------------------------------------------------------
   // decode tables
   // ----------------------------------------------------------------
   function [16:0] wait_us;
      input [3:0] code;
      input erm;
      begin
         if (erm)
         begin
            case (code)
               4'h0: wait_us = 17'h0002d;
               4'h1: wait_us = 17'h0004b;
               4'h2: wait_us = 17'h00096;
               default: wait_us = 17'h000e1;
            endcase
         end
         else
         begin
            case (code)
               4'h0: wait_us = 17'h0000f;
               4'h1: wait_us = 17'h00019;
               4'h2: wait_us = 17'h00032;
               4'h3: wait_us = 17'h0004b;
               4'h4: wait_us = 17'h0005a;
               4'h5: wait_us = 17'h00069;
               4'h6: wait_us = 17'h00078;
               4'h7: wait_us = 17'h00087;
               4'h8: wait_us = 17'h00096;
               4'h9: wait_us = 17'h000a5;
               4'ha: wait_us = 17'h000b4;
               4'hb: wait_us = 17'h000c3;
               4'hc: wait_us = 17'h000d2;
               4'hd: wait_us = 17'h000eb;
               4'he: wait_us = 17'h00104;
               default: wait_us = 17'h0011d;
            endcase
         end
      end
   endfunction

   function [16:0] drive_us;
      input [4:0] code;
      input erm;
      reg [16:0] lra;
      begin
         lra = `DRIVE_BASE_US + `DRIVE_STEP_US * {12'h000, code};
         drive_us = erm ? {lra[15:0], 1'b0} : lra;
      end
   endfunction

   function [16:0] limit_us;
      input [1:0] code;
      begin
         case (code)
            2'h1: limit_us = `OD_LIMIT1_MS * `US_PER_MS;
            2'h2: limit_us = `OD_LIMIT2_MS * `US_PER_MS;
            2'h3: limit_us = `OD_LIMIT3_MS * `US_PER_MS;
            default: limit_us = 17'h00000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // registers and apb slave
   // ----------------------------------------------------------------
   reg [7:0] settle_disch_r;
   reg [7:0] ovr_sample_r;
   reg [7:0] rd_mux;
   reg hit;
   wire [5:0] idx = paddr[7:2];
   wire setup_ph = psel & ~penable;
   wire wr_go = psel & penable & pready_r & pwrite;
   wire [7:0] status;

   always @*
   begin
      hit = (paddr[1:0] == 2'h0) && ((paddr >> 8) == {ADDR_W{1'b0}});
      rd_mux = 8'h00;
      case (idx)
         `SETTLE_DISCH_IDX: rd_mux = settle_disch_r;
         `OVR_SAMPLE_IDX: rd_mux = ovr_sample_r;
         `TIMER_STATUS_IDX: rd_mux = status;
         default: hit = 1'b0;
      endcase
   end

   // zero wait states: pready rises in the first access cycle
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         settle_disch_r <= `SETTLE_DISCH_RST;
         ovr_sample_r <= `OVR_SAMPLE_RST;
      end
      else
      begin
         pready_r <= setup_ph;
         if (setup_ph)
         begin
            prdata_r <= {24'h00_0000, rd_mux};
            pslverr_r <= ~hit;
         end
         if (wr_go && hit && idx == `SETTLE_DISCH_IDX)
            settle_disch_r <= pwdata[7:0];
         if (wr_go && hit && idx == `OVR_SAMPLE_IDX)
            ovr_sample_r <= pwdata[7:0];
      end
   end

   wire [3:0] settle_code = settle_disch_r[`SETTLE_CODE_MSB:`SETTLE_CODE_LSB];
   wire [3:0] disch_code = settle_disch_r[`DISCH_CODE_MSB:`DISCH_CODE_LSB];
   wire [1:0] od_code = ovr_sample_r[`OD_LIMIT_MSB:`OD_LIMIT_LSB];
   wire [1:0] sample_code = ovr_sample_r[`SAMPLE_CODE_MSB:`SAMPLE_CODE_LSB];
   wire [1:0] zc_code = ovr_sample_r[`ZC_CODE_MSB:`ZC_CODE_LSB];

   // ----------------------------------------------------------------
   // microsecond tick
   // ----------------------------------------------------------------
   wire us_tick;

   tick_divider #(.DIV(TICK_CYCLES)) u_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick_r(us_tick)
   );

   // ----------------------------------------------------------------
   // discharge then settle sequence
   // ----------------------------------------------------------------
   localparam [1:0] SEQ_IDLE = 2'h0;
   localparam [1:0] SEQ_DISCH = 2'h1;
   localparam [1:0] SEQ_SETTLE = 2'h2;

   reg [1:0] seq_r;
   reg [1:0] seq_nxt;
   wire disch_busy;
   wire disch_done;
   wire settle_busy;
   wire settle_done;
   wire seq_go = bemf_start && seq_r == SEQ_IDLE;

   always @*
   begin
      case (seq_r)
         SEQ_IDLE: seq_nxt = bemf_start ? SEQ_DISCH : SEQ_IDLE;
         SEQ_DISCH: seq_nxt = disch_done ? SEQ_SETTLE : SEQ_DISCH;
         SEQ_SETTLE: seq_nxt = settle_done ? SEQ_IDLE : SEQ_SETTLE;
         default: seq_nxt = SEQ_IDLE;
      endcase
   end

   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seq_r <= SEQ_IDLE;
         bemf_sample_go_r <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         bemf_sample_go_r <= settle_done;
      end
   end

   wait_timer u_disch (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(seq_go),
      .abort(1'b0),
      .len(wait_us(disch_code, erm_mode)),
      .busy_r(disch_busy),
      .done_r(disch_done)
   );

   wait_timer u_settle (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(disch_done),
      .abort(1'b0),
      .len(wait_us(settle_code, erm_mode)),
      .busy_r(settle_busy),
      .done_r(settle_done)
   );

   // ----------------------------------------------------------------
   // zero crossing timing
   // ----------------------------------------------------------------
   wire sample_busy;
   wire [16:0] sample_len = (sample_code == 2'h0) ? `SAMPLE_T0_US :
                            (sample_code == 2'h1) ? `SAMPLE_T1_US :
                            (sample_code == 2'h2) ? `SAMPLE_T2_US : `SAMPLE_T3_US;

   wait_timer u_sample (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(zc_seen & ~sample_busy),
      .abort(1'b0),
      .len(sample_len),
      .busy_r(sample_busy),
      .done_r(amp_sample_go)
   );

   wait_timer u_zc (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(zc_window_start),
      .abort(1'b0),
      .len((zc_code == 2'h0) ? `ZC_T0_US : `ZC_T1_US),
      .busy_r(zc_window_open),
      .done_r()
   );

   // ----------------------------------------------------------------
   // overdrive clamp and drive time
   // ----------------------------------------------------------------
   wire od_busy;
   wire drive_busy;

   // clamp only when enabled and not calibrating
   wait_timer u_od (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(od_start && od_code != 2'h0 && !calib_or_diag),
      .abort(od_stop | calib_or_diag),
      .len(limit_us(od_code)),
      .busy_r(od_busy),
      .done_r(od_clamp)
   );

   wait_timer u_drive (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(us_tick),
      .start(drive_start),
      .abort(1'b0),
      .len(drive_us(drive_time_code, erm_mode)),
      .busy_r(drive_busy),
      .done_r(drive_done)
   );

   assign status = {1'b0, erm_mode, drive_busy, od_busy, zc_window_open, sample_busy,
                    settle_busy, disch_busy};
endmodule // bemf_sense_timing_regs

/* core/bemf_timing_regs.vh */
`ifndef BEMF_TIMING_REGS_VH
`define BEMF_TIMING_REGS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SETTLE_DISCH_IDX 6'h28
`define OVR_SAMPLE_IDX 6'h29
`define TIMER_STATUS_IDX 6'h2a

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SETTLE_CODE_MSB 7
`define SETTLE_CODE_LSB 4
`define DISCH_CODE_MSB 3
`define DISCH_CODE_LSB 0
`define OD_LIMIT_MSB 5
`define OD_LIMIT_LSB 4
`define SAMPLE_CODE_MSB 3
`define SAMPLE_CODE_LSB 2
`define ZC_CODE_MSB 1
`define ZC_CODE_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SETTLE_DISCH_RST 8'h11
`define OVR_SAMPLE_RST 8'h0c

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// clock cycles per microsecond at 125 MHz
`define TICK_CYCLES 16'h007d
`define US_PER_MS 17'h003e8
`define OD_LIMIT1_MS 17'h00019
`define OD_LIMIT2_MS 17'h00032
`define OD_LIMIT3_MS 17'h00064
`define SAMPLE_T0_US 17'h00096
`define SAMPLE_T1_US 17'h000c8
`define SAMPLE_T2_US 17'h000fa
`define SAMPLE_T3_US 17'h0012c
`define ZC_T0_US 17'h00064
`define ZC_T1_US 17'h000c8
`define DRIVE_BASE_US 17'h001f4
`define DRIVE_STEP_US 17'h00064

`endif

/* core/tick_divider.v */
`timescale 1ns/1ns
module tick_divider #(
   parameter [15:0] DIV = 16'h007d
)(
   input wire mclk,
   input wire sys_rst,
   output reg tick_r
);
   reg [15:0] cnt_r;

   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end
      else if (cnt_r >= DIV - 16'h0001)
      begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end
endmodule // tick_divider

/* core/wait_timer.v */
`timescale 1ns/1ns
module wait_timer #(
   parameter W = 17
)(
   input wire mclk,
   input wire sys_rst,
   input wire tick,
   input wire start,
   input wire abort,
   input wire [W-1:0] len,
   output reg busy_r,
   output reg done_r
);
   reg [W-1:0] cnt_r;

   // one extra tick is counted so that a start between ticks never
   // comes out short of the programmed time
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r <= {W{1'b0}};
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (abort)
            busy_r <= 1'b0;
         else if (start)
         begin
            busy_r <= 1'b1;
            cnt_r <= len;
         end
         else if (busy_r && tick)
         begin
            if (cnt_r == {W{1'b0}})
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            else
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // wait_timer

/* verification/bemf_sense_timing_regs_bench.sv */
`timescale 1ns/1ns
module bemf_sense_timing_regs_bench;
typedef struct {logic [7:0] a; logic [7:0] v; int k; logic [4:0] c; logic e; int us;} row_t;
localparam int TK = 2;
logic mclk = 1'b0;
logic sys_rst, psel, penable, pwrite, erm_mode, calib_or_diag, od_stop, er;
logic [7:0] paddr;
logic [31:0] pwdata, rd;
logic [4:0] pulse, drive_time_code;
wire [31:0] prdata_r;
wire pready_r, pslverr_r;
wire [4:0] fin;
int fail_count = 0;
int n_compared = 0;
int n;
// ----
// rows: address, value, timer, drive code, erm, time in us
// ----
row_t rows[20] = '{
   '{8'ha0, 8'h11, 0, 5'h00, 1'b0, 50}, '{8'ha0, 8'h30, 0, 5'h00, 1'b0, 90},
   '{8'ha0, 8'h0f, 0, 5'h00, 1'b0, 300}, '{8'ha0, 8'hd0, 0, 5'h00, 1'b0, 250},
   '{8'ha0, 8'hf4, 0, 5'h00, 1'b0, 375}, '{8'ha0, 8'h5c, 0, 5'h00, 1'b0, 315},
   '{8'ha0, 8'h23, 0, 5'h00, 1'b1, 375}, '{8'ha0, 8'h01, 0, 5'h00, 1'b1, 120},
   '{8'ha0, 8'h9a, 0, 5'h00, 1'b1, 450}, '{8'ha4, 8'hc0, 1, 5'h00, 1'b0, 150},
   '{8'ha4, 8'h05, 1, 5'h00, 1'b0, 200}, '{8'ha4, 8'h09, 1, 5'h00, 1'b0, 250},
   '{8'ha4, 8'h0f, 1, 5'h00, 1'b0, 300}, '{8'ha4, 8'h00, 2, 5'h00, 1'b0, 100},
   '{8'ha4, 8'h05, 2, 5'h00, 1'b0, 200}, '{8'ha4, 8'h0f, 2, 5'h00, 1'b0, 200},
   '{8'ha4, 8'h1c, 3, 5'h00, 1'b0, 25000}, '{8'ha0, 8'h11, 4, 5'h1c, 1'b0, 3300},
   '{8'ha0, 8'h11, 4, 5'h1f, 1'b0, 3600}, '{8'ha0, 8'h11, 4, 5'h1c, 1'b1, 6600}};
always #4 mclk = ~mclk;
bemf_sense_timing_regs #(.TICK_CYCLES(16'h0002)) uut (.mclk(mclk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r), .erm_mode(erm_mode),
   .calib_or_diag(calib_or_diag), .bemf_start(pulse[0]), .bemf_sample_go_r(fin[0]),
   .zc_seen(pulse[1]), .amp_sample_go(fin[1]), .zc_window_start(pulse[2]),
   .zc_window_open(fin[2]), .od_start(pulse[3]), .od_stop(od_stop), .od_clamp(fin[3]),
   .drive_start(pulse[4]), .drive_time_code(drive_time_code), .drive_done(fin[4]));
task wrap_up;
   $display("compared %0d failed %0d", n_compared, fail_count);
   if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
   else
      $display("[ FAIL ]");
   $finish;
endtask
task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
   n_compared++;
   if (got !== exp)
   begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
   end
endtask
task rng(input int lo, input int hi, input int got);
   n_compared++;
   if (got < lo || got > hi)
   begin
      fail_count++;
      $display("CHECK FAILED cycles exp %0d..%0d got %0d", lo, hi, got);
   end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   int i;
   i = 0;
   psel <= 1'b1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge mclk);
   penable <= 1'b1;
   do
   begin
      @(posedge mclk);
      i++;
   end
   while (pready_r !== 1'b1 && i < 50);
   rd = prdata_r;
   er = pslverr_r;
   psel <= 1'b0;
   penable <= 1'b0;
   if (i >= 50)
   begin
      fail_count++;
      wrap_up;
   end
   @(posedge mclk);
endtask
// the window is timed to its closing edge, the others to their done pulse
task meas(input int k);
   pulse <= 5'h01 << k;
   @(posedge mclk);
   pulse <= 5'h00;
   n = 0;
   do
   begin
      @(posedge mclk);
      n++;
   end
   while ((k == 2 ? fin[2] !== 1'b0 : fin[k] !== 1'b1) && n < 60000);
   if (n >= 60000)
   begin
      fail_count++;
      wrap_up;
   end
   @(posedge mclk);
endtask
initial
begin
   sys_rst = 1'b1;
   {psel, penable, pwrite, erm_mode, calib_or_diag, od_stop} = 6'h00;
   {paddr, pwdata, pulse, drive_time_code} = 50'h0;
   repeat (12) @(posedge mclk);
   sys_rst <= 1'b0;
   @(posedge mclk);
   apb(1'b0, 8'ha0, 32'h0);
   chk("reset_a0", 32'h11, rd);
   apb(1'b0, 8'ha4, 32'h0);
   chk("reset_a4", 32'h0c, rd);
   foreach (rows[j])
   begin
      apb(1'b1, rows[j].a, {24'hffffff, rows[j].v});
      apb(1'b0, rows[j].a, 32'h0);
      chk("readback", {24'h0, rows[j].v}, rd);
      erm_mode <= rows[j].e;
      drive_time_code <= rows[j].c;
      meas(rows[j].k);
      rng(rows[j].us * TK, (rows[j].us + 2) * TK + 8, n);
   end
   apb(1'b0, 8'hb0, 32'h0);
   chk("unmapped_err", 32'h1, {31'h0, er});
   chk("unmapped_data", 32'h0, rd);
   apb(1'b0, 8'ha1, 32'h0);
   chk("unaligned_err", 32'h1, {31'h0, er});
   erm_mode <= 1'b1;
   apb(1'b1, 8'ha8, 32'hff);
   apb(1'b0, 8'ha8, 32'h0);
   chk("status_erm", 32'h1, {31'h0, rd[6]});
   apb(1'b1, 8'ha4, 32'h1c);
   calib_or_diag <= 1'b1;
   meas(0);
   rng(150 * TK, 152 * TK + 8, n);
   pulse <= 5'h08;
   repeat (20) @(posedge mclk);
   pulse <= 5'h00;
   apb(1'b0, 8'ha8, 32'h0);
   chk("clamp_blocked", 32'h0, {31'h0, rd[4]});
   calib_or_diag <= 1'b0;
   pulse <= 5'h08;
   @(posedge mclk);
   pulse <= 5'h00;
   apb(1'b0, 8'ha8, 32'h0);
   chk("clamp_running", 32'h1, {31'h0, rd[4]});
   od_stop <= 1'b1;
   @(posedge mclk);
   od_stop <= 1'b0;
   apb(1'b0, 8'ha8, 32'h0);
   chk("clamp_stopped", 32'h0, {31'h0, rd[4]});
   apb(1'b1, 8'ha0, 32'h5a);
   pulse <= 5'h01;
   @(posedge mclk);
   pulse <= 5'h00;
   sys_rst <= 1'b1;
   @(posedge mclk);
   #1 chk("reset_outputs", 32'h0, {26'h0, pready_r, fin});
   @(posedge mclk);
   sys_rst <= 1'b0;
   @(posedge mclk);
   apb(1'b0, 8'ha0, 32'h0);
   chk("rerun_a0", 32'h11, rd);
   wrap_up;
end
endmodule // bemf_sense_timing_regs_bench
bind bemf_sense_timing_regs bemf_sense_timing_regs_chk chk_i (.mclk(mclk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pready_r(pready_r), .pslverr_r(pslverr_r),
   .calib_or_diag(calib_or_diag), .bemf_start(bemf_start), .bemf_sample_go_r(bemf_sample_go_r),
   .zc_seen(zc_seen), .amp_sample_go(amp_sample_go), .zc_window_start(zc_window_start),
   .zc_window_open(zc_window_open), .od_clamp(od_clamp), .drive_start(drive_start),
   .drive_done(drive_done));

/* verification/bemf_sense_timing_regs_chk.sv */
`timescale 1ns/1ns
module bemf_sense_timing_regs_chk (
   input wire mclk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pready_r,
   input wire pslverr_r,
   input wire calib_or_diag,
   input wire bemf_start,
   input wire bemf_sample_go_r,
   input wire zc_seen,
   input wire amp_sample_go,
   input wire zc_window_start,
   input wire zc_window_open,
   input wire od_clamp,
   input wire drive_start,
   input wire drive_done
);
// ----
// checks
// ----
default clocking cb @(posedge mclk); endclocking
default disable iff (sys_rst);
// the shortest wait is well over eight cycles at any tick rate
sequence s_go_quiet;
   !bemf_sample_go_r [*8];
endsequence
sequence s_amp_quiet;
   !amp_sample_go [*8];
endsequence
a_ready_access: assert property (pready_r |-> psel && penable)
   else $error("ready outside access");
a_ready_once: assert property (pready_r |=> !pready_r)
   else $error("ready longer than one cycle");
a_err_ready: assert property ($rose(pslverr_r) |-> pready_r)
   else $error("error without ready");
a_go_pulse: assert property (bemf_sample_go_r |=> !bemf_sample_go_r)
   else $error("sample go too long");
a_go_wait: assert property (bemf_start |=> s_go_quiet)
   else $error("sample go too early");
a_amp_wait: assert property (zc_seen |=> s_amp_quiet)
   else $error("amplitude sample too early");
a_win_open: assert property (zc_window_start |-> ##[1:2] zc_window_open)
   else $error("window did not open");
a_clamp_calib: assert property (calib_or_diag && $past(calib_or_diag) |-> !od_clamp)
   else $error("clamp during calibration");
a_drive_wait: assert property (drive_start |=> !drive_done [*8])
   else $error("drive done too early");
endmodule // bemf_sense_timing_regs_chk
